// [pkg/lin_mode_cfg.svh]
`ifndef LIN_MODE_CFG_SVH
`define LIN_MODE_CFG_SVH
// register indices, byte address is four times the index
`define LIN_IDX_STATUS 3'h0
`define LIN_IDX_DATA 3'h1
`define LIN_IDX_MANT 3'h2
`define LIN_IDX_CR1 3'h3
`define LIN_IDX_CR2 3'h4
`define LIN_IDX_CR3 3'h5
`define LIN_IDX_HLEN 3'h6
`define LIN_IDX_FRAC 3'h7
// control_register_two fields
`define LIN_CR2_MUTE 1
`define LIN_CR2_SBK 0
// status_register fields
`define LIN_SR_RXFULL 5
`define LIN_SR_HDRERR 3
// reset values and header length markers
`define LIN_RST_CR 8'h00
`define LIN_RST_DIV 8'h00
`define LIN_RST_HLEN 8'h00
`define LIN_HLEN_BREAK 8'hFF
`define LIN_HLEN_TMO 8'h00
// bit and edge counts
`define LIN_RX_BREAK_BITS 11
`define LIN_TX_BREAK_MASTER 13
`define LIN_TX_BREAK_PLAIN 10
`define LIN_HDR_MAX_BITS 57
`define LIN_SYNC_FALLS 5
`endif

// [pkg/lin_pkg.sv]
package lin_pkg;
    // active divider: mantissa and sixteenths
    typedef struct packed {
        logic [7:0] mant;
        logic [3:0] frac;
    } divider_t;
    // control_register_three layout, bit 7 first
    typedef struct packed {
        logic upd_deferred;
        logic lin_enable;
        logic slave_select;
        logic auto_sync;
        logic hdr_method;
        logic hdr_irq_en;
        logic hdr_flag;
        logic sync_state;
    } lin_ctrl_t;
    // header receive states
    typedef enum logic [2:0] {
        HS_IDLE, HS_BREAK, HS_DELIM, HS_SYNC, HS_IDENT
    } hdr_state_t;
endpackage : lin_pkg

// [logic/lin_mode_control_divider.sv]
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lin_mode_cfg.svh"
module lin_mode_control_divider #(
    parameter int unsigned RX_BREAK_BITS = `LIN_RX_BREAK_BITS,
    parameter int unsigned TX_BREAK_MASTER = `LIN_TX_BREAK_MASTER,
    parameter int unsigned TX_BREAK_PLAIN = `LIN_TX_BREAK_PLAIN,
    parameter int unsigned HDR_MAX_BITS = `LIN_HDR_MAX_BITS
) (
    input wire logic clk_i, // 50 MHz system clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic [4:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [3:0] avs_byteenable_i, // lane 0 carries data
    input wire logic [31:0] avs_writedata_i, // write data
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // high while not ready
    input wire logic serial_rx_pin_i, // receive line level
    input wire logic rx_full_i, // receive buffer full flag
    input wire logic plain_wake_i, // plain serial wake event pulse
    input wire logic tx_idle_i, // current word fully shifted
    input wire logic tx_bit_tick_i, // one pulse per transmit bit
    output logic tx_break_o, // force transmit line low
    output logic mute_o, // receiver in mute mode
    output lin_pkg::divider_t baud_div_o, // active baud divider
    output logic baud_clk_en_o, // serial clocks running
    output logic lin_master_o, // master mode selected
    output logic lin_slave_o, // slave mode selected
    output logic header_irq_o // header interrupt request
);
    import lin_pkg::*;

    localparam logic [7:0] BRK_Q = 8'(RX_BREAK_BITS * 4);
    localparam logic [7:0] HDR_Q = 8'(HDR_MAX_BITS * 4);
    localparam logic [2:0] SYNC_F = 3'(`LIN_SYNC_FALLS);
    localparam logic [3:0] TXB_M = 4'(TX_BREAK_MASTER);
    localparam logic [3:0] TXB_P = 4'(TX_BREAK_PLAIN);

    // ************************************************
    // parameter checks
    // ************************************************
    if (RX_BREAK_BITS < 1 || RX_BREAK_BITS > 63 || HDR_MAX_BITS > 63 ||
        TX_BREAK_MASTER < 1 || TX_BREAK_MASTER > 15 ||
        TX_BREAK_PLAIN < 1 || TX_BREAK_PLAIN > 15) begin : g_chk
        $error("lin_mode_control_divider: unsupported bit counts");
    end

    // ************************************************
    // bus slave
    // ************************************************
    logic wait_q;
    logic [31:0] rdata_q;
    logic acc, wr, rd, slave, master;
    logic [2:0] idx;
    logic [7:0] wd, rd_val;
    logic mute_q, sbk_q, hdr_err_q, arm_q, rx_full_q, rx_prev_q;
    lin_ctrl_t cr_q;
    divider_t div_q, shadow_q;
    logic [7:0] hlen_q;
    hdr_state_t st_q;
    logic hdr_set, brk_evt, tmo_evt, as_upd, rx_rise, fall;
    divider_t as_val;

    assign idx = avs_address_i[4:2];
    assign wd = avs_writedata_i[7:0];
    // accepted at the edge where waitrequest is seen low
    assign acc = (avs_read_i | avs_write_i) & ~wait_q;
    assign wr = acc & avs_write_i & avs_byteenable_i[0];
    assign rd = acc & avs_read_i;
    assign master = cr_q.lin_enable & ~cr_q.slave_select;
    assign slave = cr_q.lin_enable & cr_q.slave_select;
    assign rx_rise = rx_full_i & ~rx_full_q;
    assign fall = rx_prev_q & ~serial_rx_pin_i;

    // read mux; data and cr1 slots belong to the plain path, read zero
    always_comb begin
        rd_val = 8'h00;
        case (idx)
            `LIN_IDX_STATUS: begin
                rd_val[`LIN_SR_RXFULL] = rx_full_i;
                rd_val[`LIN_SR_HDRERR] = hdr_err_q;
            end
            `LIN_IDX_CR2: rd_val = {6'h00, mute_q, sbk_q};
            `LIN_IDX_CR3: rd_val = cr_q;
            // divider overlays the prescaler slots in slave mode
            `LIN_IDX_MANT: rd_val = slave ? div_q.mant : 8'h00;
            `LIN_IDX_FRAC: rd_val = slave ? {4'h0, div_q.frac} : 8'h00;
            // header length visible only when in use
            `LIN_IDX_HLEN: rd_val = (slave & (cr_q.auto_sync | cr_q.hdr_method)) ?
                hlen_q : 8'h00;
            default: rd_val = 8'h00;
        endcase
    end

    // one wait state, then answer; read data registered with it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~((avs_read_i | avs_write_i) & wait_q);
            if ((avs_read_i | avs_write_i) & wait_q) begin
                rdata_q <= {24'h00_0000, rd_val};
            end
        end
    end

    // ************************************************
    // control register two
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mute_q <= 1'b0;
            sbk_q <= 1'b0;
        end else begin
            // wake-up clears mute, beating a same-cycle write
            // slave wakes on header, else plain wake event
            if (slave ? hdr_set : plain_wake_i) begin
                mute_q <= 1'b0;
            // locked while buffer full in slave mode
            end else if (wr && idx == `LIN_IDX_CR2 && !(slave && rx_full_i)) begin
                mute_q <= wd[`LIN_CR2_MUTE];
            end
            if (wr && idx == `LIN_IDX_CR2) begin
                sbk_q <= wd[`LIN_CR2_SBK];
            end
        end
    end

    // ************************************************
    // control register three and flags
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cr_q <= `LIN_RST_CR;
            arm_q <= 1'b0;
            hdr_err_q <= 1'b0;
            rx_full_q <= 1'b0;
        end else begin
            rx_full_q <= rx_full_i;
            if (wr && idx == `LIN_IDX_CR3) begin
                cr_q.lin_enable <= wd[6];
                cr_q.slave_select <= wd[5];
                cr_q.auto_sync <= wd[4];
                cr_q.hdr_method <= wd[3];
                cr_q.hdr_irq_en <= wd[2];
            end
            // hardware clear on new character wins over a write
            if (rx_rise) begin
                cr_q.upd_deferred <= 1'b0;
            end else if (wr && idx == `LIN_IDX_CR3) begin
                cr_q.upd_deferred <= wd[7];
            end
            // status access arms the flag clear
            if (acc) begin
                arm_q <= (idx == `LIN_IDX_STATUS);
            end
            // set wins over the clear sequence
            if (hdr_set) begin
                cr_q.hdr_flag <= 1'b1;
            end else if (rd && arm_q && idx == `LIN_IDX_CR3) begin
                cr_q.hdr_flag <= 1'b0;
            end
            if (tmo_evt) begin
                hdr_err_q <= 1'b1;
            end else if (rd && arm_q && idx == `LIN_IDX_DATA) begin
                hdr_err_q <= 1'b0;
            end
            // sync state mirrors the header machine
            cr_q.sync_state <= (st_q == HS_DELIM || st_q == HS_SYNC);
        end
    end

    // ************************************************
    // baud divider
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q <= {`LIN_RST_DIV, 4'h0};
            shadow_q <= {`LIN_RST_DIV, 4'h0};
        end else begin
            // fraction only lands in the shadow
            if (wr && slave && idx == `LIN_IDX_FRAC) begin
                shadow_q.frac <= wd[3:0];
            end else if (as_upd) begin
                shadow_q.frac <= as_val.frac;
            end
            if (wr && slave && idx == `LIN_IDX_MANT) begin
                shadow_q.mant <= wd;
            end else if (as_upd) begin
                shadow_q.mant <= as_val.mant;
            end
            // auto-sync first, then immediate mantissa write
            if (as_upd) begin
                div_q <= as_val;
            end else if (wr && slave && idx == `LIN_IDX_MANT && !cr_q.upd_deferred) begin
                div_q <= {wd, shadow_q.frac};
            // deferred reload at next character, old value if unwritten
            end else if (rx_rise && cr_q.upd_deferred && slave) begin
                div_q <= shadow_q;
            end
        end
    end

    // ************************************************
    // header receive machine
    // ************************************************
    logic [9:0] qcnt_q;
    logic [7:0] lowq_q, hdrq_q;
    logic [15:0] cyc_q;
    logic [2:0] falls_q;
    logic qtick;
    // quarter bit is four sixteenths of the divider
    assign qtick = (qcnt_q == 10'(div_q[11:2] - 10'h001));
    assign as_val = divider_t'(cyc_q[14:3]);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= HS_IDLE;
            qcnt_q <= 10'h000;
            lowq_q <= 8'h00;
            hdrq_q <= 8'h00;
            cyc_q <= 16'h0000;
            falls_q <= 3'h0;
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= serial_rx_pin_i;
            qcnt_q <= qtick ? 10'h000 : 10'(qcnt_q + 10'h001);
            if (qtick && hdrq_q != 8'hFF) begin
                hdrq_q <= 8'(hdrq_q + 8'h01);
            end
            // machine held idle outside slave mode
            // and while the serial clock is stopped
            if (!slave || div_q.mant == 8'h00) begin
                st_q <= HS_IDLE;
            // software clear aborts the sync state
            end else if (wr && idx == `LIN_IDX_CR3 && !wd[0] &&
                         (st_q == HS_DELIM || st_q == HS_SYNC)) begin
                st_q <= HS_IDLE;
            end else if (tmo_evt) begin
                st_q <= HS_IDLE;
            end else begin
                case (st_q)
                    HS_IDLE: begin
                        if (fall) begin
                            st_q <= HS_BREAK;
                            qcnt_q <= 10'h000;
                            lowq_q <= 8'h00;
                            hdrq_q <= 8'h00;
                        end
                    end
                    HS_BREAK: begin
                        if (serial_rx_pin_i) begin
                            st_q <= HS_IDLE;
                        end else if (qtick) begin
                            lowq_q <= 8'(lowq_q + 8'h01);
                            // 11 low bit times make a break
                            if (8'(lowq_q + 8'h01) == BRK_Q) begin
                                st_q <= HS_DELIM;
                            end
                        end
                    end
                    HS_DELIM: begin
                        if (fall) begin
                            st_q <= HS_SYNC;
                            // start at one so the first falling edge's cycle is counted
                            cyc_q <= 16'h0001;
                            falls_q <= 3'h1;
                        end
                    end
                    HS_SYNC: begin
                        // time from first to last falling edge
                        cyc_q <= 16'(cyc_q + 16'h0001);
                        if (fall) begin
                            falls_q <= 3'(falls_q + 3'h1);
                            if (3'(falls_q + 3'h1) == SYNC_F) begin
                                st_q <= cr_q.hdr_method ? HS_IDENT : HS_IDLE;
                            end
                        end
                    end
                    HS_IDENT: begin
                        if (rx_rise) begin
                            st_q <= HS_IDLE;
                        end
                    end
                    default: st_q <= HS_IDLE;
                endcase
            end
        end
    end

    // header events
    assign brk_evt = slave && st_q == HS_BREAK && !serial_rx_pin_i && qtick &&
        8'(lowq_q + 8'h01) == BRK_Q;
    // break alone, or identifier after break and sync
    assign hdr_set = cr_q.hdr_method ? (slave && st_q == HS_IDENT && rx_rise) : brk_evt;
    assign tmo_evt = slave && st_q != HS_IDLE && st_q != HS_BREAK && hdrq_q > HDR_Q;
    // measurement only applied when auto-sync is on
    assign as_upd = slave && cr_q.auto_sync && st_q == HS_SYNC && fall &&
        3'(falls_q + 3'h1) == SYNC_F;

    // ************************************************
    // header length capture
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hlen_q <= `LIN_RST_HLEN;
        end else begin
            // header value wins over break marker
            // quarters left of the 57 bit budget
            if (hdr_set) begin
                hlen_q <= 8'(HDR_Q - hdrq_q - {7'h00, qtick}); // quarter ending now counts
            end else if (brk_evt) begin
                hlen_q <= `LIN_HLEN_BREAK;
            end else if (tmo_evt) begin
                hlen_q <= `LIN_HLEN_TMO;
            end
        end
    end

    // ************************************************
    // break transmission
    // ************************************************
    logic pend_q, txb_q;
    logic [3:0] tbits_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_q <= 1'b0;
            txb_q <= 1'b0;
            tbits_q <= 4'h0;
        end else begin
            // a rising send-break request is remembered
            if (wr && idx == `LIN_IDX_CR2 && wd[`LIN_CR2_SBK] && !sbk_q && !slave) begin
                pend_q <= 1'b1;
            end else if (!txb_q && tx_idle_i && pend_q) begin
                pend_q <= 1'b0;
            end
            // slave mode never starts a break
            if (slave) begin
                txb_q <= 1'b0;
            end else if (!txb_q) begin
                if ((sbk_q || pend_q) && tx_idle_i) begin
                    txb_q <= 1'b1;
                    tbits_q <= 4'h0;
                end
            end else if (tx_bit_tick_i) begin
                tbits_q <= 4'(tbits_q + 4'h1);
                // master break is 13 bit times
                if (4'(tbits_q + 4'h1) == (master ? TXB_M : TXB_P)) begin
                    txb_q <= 1'b0;
                end
            end
        end
    end

    // ************************************************
    // registered outputs
    // ************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            baud_clk_en_o <= 1'b1;
            lin_master_o <= 1'b0;
            lin_slave_o <= 1'b0;
            header_irq_o <= 1'b0;
        end else begin
            // clocks stop in slave mode with zero mantissa
            baud_clk_en_o <= !(slave && div_q.mant == 8'h00);
            lin_master_o <= master;
            lin_slave_o <= slave;
            header_irq_o <= slave && cr_q.hdr_irq_en && cr_q.hdr_flag;
        end
    end

    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign tx_break_o = txb_q;
    assign mute_o = mute_q;
    assign baud_div_o = div_q;
endmodule : lin_mode_control_divider

// [bench/lin_mode_control_divider_sva.sv]
`timescale 1ns/1ps
// *****
// port checker
// *****
module lin_mode_checker (
    input wire logic clk_i, // clock
    input wire logic rst_b_i, // reset
    input wire logic [4:0] avs_address_i, // address
    input wire logic avs_read_i, // read
    input wire logic avs_write_i, // write
    input wire logic [31:0] avs_readdata_o, // read data
    input wire logic avs_waitrequest_o, // wait
    input wire logic plain_wake_i, // wake
    input wire logic tx_break_o, // break
    input wire logic mute_o, // mute
    input wire lin_pkg::divider_t baud_div_o, // divider
    input wire logic baud_clk_en_o, // clock enable
    input wire logic lin_master_o, // master
    input wire logic lin_slave_o, // slave
    input wire logic header_irq_o // interrupt
);
    import lin_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // bus answers after exactly one wait cycle, for one cycle only
    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    answer_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer held too long");
    frac_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i[4:2] == 3'h7
        |-> avs_readdata_o[31:4] == 28'h0) else $error("fraction high bits set");
    // mode outputs lag the control register, so the slave break check looks one cycle back
    mode_excl_a: assert property (!(lin_master_o && lin_slave_o))
        else $error("master and slave together");
    slave_nobreak_a: assert property (
        lin_slave_o && $past(lin_slave_o) |-> !tx_break_o) else $error("break in slave");
    clk_gate_a: assert property (
        lin_slave_o && baud_div_o.mant == 8'h00 && $stable(baud_div_o) |-> !baud_clk_en_o)
        else $error("clock runs with zero mantissa");
    irq_slave_a: assert property (header_irq_o |-> lin_slave_o)
        else $error("header irq outside slave");
    wake_clear_a: assert property (
        plain_wake_i && !lin_slave_o ##1 !lin_slave_o |-> !mute_o) else $error("mute kept");
endmodule : lin_mode_checker

bind lin_mode_control_divider lin_mode_checker chk (.clk_i, .rst_b_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .plain_wake_i,
    .tx_break_o, .mute_o, .baud_div_o, .baud_clk_en_o, .lin_master_o, .lin_slave_o,
    .header_irq_o);

// [bench/lin_node_model.sv]
`timescale 1ns/1ps
// *****
// far-side master node
// *****
module lin_node_model (
    input wire logic clk_i, // bench clock
    output logic line_o // bus level, pulled up when idle
);
    int bit_cyc = 48; // slower than the slave divider, so auto-sync must move
    // released line rests at the pull-up level
    initial line_o = 1'b1;
    // hold one level for n bit times
    task automatic drive(input logic v, input int n);
        line_o <= v;
        repeat (n * bit_cyc) @(posedge clk_i);
    endtask : drive
    // start, eight bits lsb first, stop
    task automatic send_byte(input logic [7:0] b);
        drive(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            drive(b[i], 1);
        end
        drive(1'b1, 1);
    endtask : send_byte
    task automatic send_header(input logic [7:0] id);
        drive(1'b0, 13);
        drive(1'b1, 1);
        send_byte(8'h55);
        send_byte(id);
    endtask : send_header
endmodule : lin_node_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("wrong value at %0t: got %h want %h", $time, (g), (e)); \
    end \
end
module tb_top;
    import lin_pkg::*;
    typedef struct packed {logic wr; logic [4:0] a; logic [7:0] d;} row_t;
    logic clk_i = 1'b0, rst_b_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic avs_waitrequest_o, serial_rx_pin_i, rx_full_i = 1'b0, plain_wake_i = 1'b0;
    logic tx_idle_i = 1'b1, tx_bit_tick_i = 1'b0, tx_break_o, mute_o, baud_clk_en_o;
    logic lin_master_o, lin_slave_o, header_irq_o;
    logic [1:0] tick_q = 2'h0;
    divider_t baud_div_o;
    int n_errors = 0, compares = 0, nbrk = 0;
    // slave-mode register walk: writes, and reads with expected data
    row_t rows [12] = '{'{1'b1, 5'h1C, 8'hF8}, '{1'b0, 5'h08, 8'h00}, '{1'b1, 5'h08, 8'h02},
        '{1'b0, 5'h08, 8'h02}, '{1'b0, 5'h1C, 8'h08}, '{1'b1, 5'h0C, 8'hFF},
        '{1'b0, 5'h0C, 8'h00}, '{1'b0, 5'h04, 8'h00}, '{1'b0, 5'h18, 8'h00},
        '{1'b1, 5'h10, 8'h02}, '{1'b0, 5'h10, 8'h02}, '{1'b1, 5'h10, 8'h00}};
    lin_mode_control_divider dut (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
        .avs_waitrequest_o, .serial_rx_pin_i, .rx_full_i, .plain_wake_i, .tx_idle_i,
        .tx_bit_tick_i, .tx_break_o, .mute_o, .baud_div_o, .baud_clk_en_o, .lin_master_o,
        .lin_slave_o, .header_irq_o);
    lin_node_model node (.clk_i, .line_o(serial_rx_pin_i));
    // *****
    // clock, bit ticks, bus
    // *****
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // a tick every fourth cycle; ticks seen during a break are counted
    always @(posedge clk_i) begin
        tick_q <= tick_q + 2'h1;
        tx_bit_tick_i <= (tick_q == 2'h3);
        if (tx_break_o && tx_bit_tick_i) nbrk++;
    end
    // request held until waitrequest is sampled low, then released for one edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        avs_address_i <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge clk_i);
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, {24'h0, e})
    endtask : rd
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    // *****
    // tests
    // *****
    initial begin
        repeat (10000) @(posedge clk_i);
        n_errors++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        `CHK(baud_div_o, 12'h000)
        `CHK(baud_clk_en_o, 1'b1)
        rd(5'h14, 8'h00);
        bus(1'b1, 5'h08, 8'h05);
        rd(5'h08, 8'h00);
        rd(5'h18, 8'h00);
        bus(1'b1, 5'h14, 8'h60);
        repeat (2) @(posedge clk_i);
        `CHK(baud_clk_en_o, 1'b0)
        `CHK(lin_slave_o, 1'b1)
        for (int i = 0; i < 12; i++) begin
            if (rows[i].wr) begin
                bus(1'b1, rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, rows[i].d);
            end
        end
        `CHK(baud_div_o, 12'h028)
        `CHK(baud_clk_en_o, 1'b1)
        // break-method header with auto-sync, muted, interrupt enabled
        bus(1'b1, 5'h14, 8'h74);
        bus(1'b1, 5'h10, 8'h02);
        fork
            node.send_header(8'h3C);
            begin
                repeat (700) @(posedge clk_i);
                rd(5'h18, 8'hB8);
            end
        join
        repeat (2) @(posedge clk_i);
        `CHK(baud_div_o, 12'h030)
        `CHK(mute_o, 1'b0)
        `CHK(header_irq_o, 1'b1)
        bus(1'b0, 5'h00, 8'h00);
        rd(5'h14, 8'h76);
        rd(5'h14, 8'h74);
        `CHK(header_irq_o, 1'b0)
        // identifier-method header with a deferred divider update
        bus(1'b1, 5'h14, 8'hE8);
        bus(1'b1, 5'h1C, 8'h00);
        bus(1'b1, 5'h08, 8'h04);
        `CHK(baud_div_o, 12'h030)
        fork
            node.send_header(8'h3C);
            begin
                repeat (700) @(posedge clk_i);
                rd(5'h14, 8'hE9);
                rd(5'h18, 8'hFF);
            end
        join
        rd(5'h14, 8'hE8);
        rx_full_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK(baud_div_o, 12'h040)
        rd(5'h14, 8'h6A);
        bus(1'b1, 5'h10, 8'h02);
        rd(5'h10, 8'h00);
        rx_full_i <= 1'b0;
        // master: plain wake, then a break armed while a word is shifting
        bus(1'b1, 5'h14, 8'h40);
        bus(1'b1, 5'h10, 8'h02);
        `CHK(mute_o, 1'b1)
        plain_wake_i <= 1'b1;
        @(posedge clk_i);
        plain_wake_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK(mute_o, 1'b0)
        `CHK(lin_master_o, 1'b1)
        tx_idle_i <= 1'b0;
        bus(1'b1, 5'h10, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        repeat (20) @(posedge clk_i);
        `CHK(tx_break_o, 1'b0)
        tx_idle_i <= 1'b1;
        while (tx_break_o !== 1'b1) begin
            @(posedge clk_i);
        end
        while (tx_break_o !== 1'b0) begin
            @(posedge clk_i);
        end
        `CHK(nbrk, 13)
        // slave ignores send break; disabled mode clears both mode outputs
        bus(1'b1, 5'h14, 8'h60);
        bus(1'b1, 5'h10, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        repeat (60) @(posedge clk_i);
        `CHK(nbrk, 13)
        bus(1'b1, 5'h14, 8'h20);
        repeat (2) @(posedge clk_i);
        `CHK({lin_master_o, lin_slave_o}, 2'b00)
        // disabled mode: set-then-clear still sends one plain-length break
        bus(1'b1, 5'h10, 8'h01);
        bus(1'b1, 5'h10, 8'h00);
        repeat (60) @(posedge clk_i);
        `CHK(nbrk, 23)
        summarize();
    end
endmodule : tb_top
